// [design/scs_entry_table.sv]
// scs_entry_table: maps subroutine numbers to entry addresses and owning task.
// assumes the loader writes entries while the program is stopped.
`default_nettype none
module scs_entry_table (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         load_en,
	input  wire logic [scs_pkg::NUM_W-1:0]    load_num,
	input  wire scs_pkg::scs_entry_t          load_entry,
	input  wire logic [scs_pkg::NUM_W-1:0]    look_num,
	output scs_pkg::scs_entry_t               look_entry
);
	scs_pkg::scs_entry_t tbl [scs_pkg::NUM_SUBS];
	logic [scs_pkg::NUM_SUBS-1:0] present;

	assign look_entry = present[look_num] ? tbl[look_num] : '0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			present <= '0;
		end else if (load_en) begin
			present[load_num] <= load_entry.valid;
			tbl[load_num]     <= load_entry;
		end
	end
endmodule : scs_entry_table
`default_nettype wire

// [design/scs_pkg.sv]
// scs_pkg: shared constants and carrier types for the subroutine call sequencer.
// assumes a single scan clock and a synchronous active-high reset.
`default_nettype none
package scs_pkg;
	localparam int          PC_W        = 16;
	localparam int          WORD_W      = 16;
	localparam int          NUM_W       = 10;
	localparam int          TASK_W      = 8;
	localparam int          STACK_DEPTH = 16;
	localparam int          SP_W        = 5;
	localparam int          PARAM_WORDS = 4;
	localparam int          NUM_SUBS    = 1024;
	localparam logic [9:0]  NUM_MAX     = 10'h3ff;
	localparam logic [9:0]  NUM_MAX_RED = 10'h0ff;
	localparam logic [9:0]  OPC_NOP     = 10'h000;
	localparam logic [9:0]  OPC_CALL    = 10'h05b;
	localparam logic [9:0]  OPC_ENTRY   = 10'h05c;
	localparam logic [9:0]  OPC_RETURN  = 10'h05d;
	localparam logic [9:0]  OPC_PCALL   = 10'h063;
	// macro area word indices: inputs 0..3, outputs 4..7
	localparam logic [2:0]  MACRO_IN0   = 3'h0;
	localparam logic [2:0]  MACRO_OUT0  = 3'h4;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

	typedef enum logic [2:0] {
		SCS_ERR_NONE,
		SCS_ERR_DEPTH,
		SCS_ERR_MISSING,
		SCS_ERR_SELF,
		SCS_ERR_ACTIVE,
		SCS_ERR_TASK
	} scs_err_t;

	typedef struct packed {
		logic [9:0]        opcode;
		logic [NUM_W-1:0]  num;
		logic [PC_W-1:0]   src;
		logic [PC_W-1:0]   dst;
		logic              interlocked;
		logic [TASK_W-1:0] task_id;
	} scs_instr_t;

	typedef struct packed {
		logic [PC_W-1:0]  ret_pc;
		logic [NUM_W-1:0] num;
		logic             param;
		logic [PC_W-1:0]  dst;
	} scs_frame_t;

	typedef struct packed {
		logic              valid;
		logic [PC_W-1:0]   pc;
		logic [TASK_W-1:0] task_id;
	} scs_entry_t;
endpackage : scs_pkg
`default_nettype wire

// [design/scs_sequencer.sv]
// scs_sequencer: call, return and parameter-copy control of the execution engine.
// assumes one instruction offered at a time with a valid/ready handshake and a
// word-wide data memory port that answers reads in the same cycle.
`default_nettype none

// Functional notes
// R1 - nesting up to 16 levels; deeper call sets the error flag
// R2 - call to a number with no entry sets the error flag
// R3 - a subroutine calling itself sets the error flag
// R4 - call to any subroutine already on the stack sets the error flag
// R5 - target defined outside the current task is rejected with error
// R6 - error flag cleared on every call that passes all checks
// R7 - valid call runs entry to return marker, then resumes after call
// R8 - same subroutine may be called from many call sites
// R9 - call inside an interlocked section is a no-op, no transfer
// R10 - subroutine numbers 0 to 1023 accepted
// R11 - reduced variant limits subroutine numbers to 0 to 255
// R12 - program must give each subroutine a unique number
// R13 - parameter call resolves and checks exactly like plain call
// R14 - parameter call copies four source words into macro inputs first
// R15 - after return, four macro outputs copied to destination, then resume
// R16 - exactly four input and four output words are moved
// R17 - program saves the shared eight-word macro area before nesting
// R18 - interrupt tasks using parameter calls must save macro words
// R19 - opcode 092 is entry marker, opcode 093 is return marker
// R20 - return marker pops stack, copies outputs first for parameter call
// R21 - opcode 091 is the plain call instruction
// R22 - return addresses kept in a 16-entry last-in first-out stack
module scs_sequencer #(
	parameter bit REDUCED = 1'b0
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       instr_valid,
	input  wire scs_pkg::scs_instr_t        instr,
	input  wire logic [scs_pkg::PC_W-1:0]   instr_pc,
	output logic                            instr_ready,
	output logic                            jump,
	output logic [scs_pkg::PC_W-1:0]        jump_pc,
	output logic                            error_flag,
	output scs_pkg::scs_err_t               err_cause,
	output logic [scs_pkg::SP_W-1:0]        nest_depth,
	input  wire logic                       load_en,
	input  wire logic [scs_pkg::NUM_W-1:0]  load_num,
	input  wire scs_pkg::scs_entry_t        load_entry,
	output logic                            mem_rd,
	output logic                            mem_wr,
	output logic [scs_pkg::PC_W-1:0]        mem_addr,
	output logic [scs_pkg::WORD_W-1:0]      mem_wdata,
	input  wire logic [scs_pkg::WORD_W-1:0] mem_rdata,
	output logic [2:0]                      macro_idx,
	output logic                            macro_wr,
	output logic [scs_pkg::WORD_W-1:0]      macro_wdata,
	input  wire logic [scs_pkg::WORD_W-1:0] macro_rdata
);
	typedef enum logic [1:0] {
		SCS_IDLE,
		SCS_COPY_IN,
		SCS_COPY_OUT
	} scs_state_t;

	scs_state_t          state;
	scs_state_t          next_state;
	logic [1:0]          cnt;
	logic [scs_pkg::PC_W-1:0] base;
	logic [scs_pkg::PC_W-1:0] pend_pc;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic is_call;
	logic is_pcall;
	logic is_ret;
	logic is_entry;
	logic any_call;
	logic nop_call;

	// opcode match shared by every decode
	function automatic logic opc_is(input logic [9:0] code, input logic [9:0] want);
		return code == want;
	endfunction : opc_is

	// R21 plain call decode
	assign is_call  = opc_is(instr.opcode, scs_pkg::OPC_CALL);
	// R13 parameter call shares decode
	assign is_pcall = opc_is(instr.opcode, scs_pkg::OPC_PCALL);
	// R19 return marker decode
	assign is_ret   = opc_is(instr.opcode, scs_pkg::OPC_RETURN);
	// R19 entry marker passes through
	assign is_entry = opc_is(instr.opcode, scs_pkg::OPC_ENTRY);
	// R9 interlocked call ignored
	assign nop_call = (is_call | is_pcall) & instr.interlocked;
	assign any_call = (is_call | is_pcall) & ~instr.interlocked;

	// ------------------------------------------------------------
	// entry table and return stack
	// ------------------------------------------------------------
	scs_pkg::scs_entry_t entry;
	scs_pkg::scs_frame_t top;
	scs_pkg::scs_frame_t new_frame;
	scs_pkg::scs_frame_t stack_frame;
	scs_pkg::scs_frame_t pend_frame;
	// one bit per number, so the already-active check is one look-up
	logic [scs_pkg::NUM_SUBS-1:0] active;
	logic push;
	logic pop;

	scs_entry_table u_table (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.load_en    (load_en),
		.load_num   (load_num),
		.load_entry (load_entry),
		.look_num   (instr.num),
		.look_entry (entry)
	);

	// R22 return address stack
	scs_stack u_stack (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.push       (push),
		.pop        (pop),
		.push_frame (stack_frame),
		.top_frame  (top),
		.depth      (nest_depth),
		.active     (active)
	);

	// ------------------------------------------------------------
	// call checks
	// ------------------------------------------------------------
	logic range_bad;
	logic depth_bad;
	logic self_bad;
	logic act_bad;
	logic task_bad;
	logic call_ok;
	scs_pkg::scs_err_t cause;

	// R10 R11 number range
	assign range_bad = REDUCED ? (instr.num > scs_pkg::NUM_MAX_RED) : (instr.num > scs_pkg::NUM_MAX);
	// R1 nesting limit
	assign depth_bad = nest_depth == 5'(scs_pkg::STACK_DEPTH);
	// R3 recursion
	assign self_bad  = (nest_depth != '0) && (top.num == instr.num);
	// R4 already active
	assign act_bad   = active[instr.num];
	// R5 other task
	assign task_bad  = entry.task_id != instr.task_id;

	// R2 missing entry is checked with range
	assign cause = depth_bad                 ? scs_pkg::SCS_ERR_DEPTH :
	               (range_bad | ~entry.valid) ? scs_pkg::SCS_ERR_MISSING :
	               self_bad                  ? scs_pkg::SCS_ERR_SELF :
	               act_bad                   ? scs_pkg::SCS_ERR_ACTIVE :
	               task_bad                  ? scs_pkg::SCS_ERR_TASK :
	                                           scs_pkg::SCS_ERR_NONE;
	assign call_ok = cause == scs_pkg::SCS_ERR_NONE;

	// ------------------------------------------------------------
	// handshake and stack control
	// ------------------------------------------------------------
	logic idle;
	logic take;
	logic ret_take;
	logic out_last;
	logic cnt_last;

	assign idle        = state == SCS_IDLE;
	assign instr_ready = idle;
	assign take        = instr_valid & idle;
	// a return at depth zero is ignored
	assign ret_take    = take & is_ret & (nest_depth != '0);
	// fourth word of a copy
	assign cnt_last    = cnt == 2'h3;
	assign out_last    = (state == SCS_COPY_OUT) && cnt_last;

	// R8 frame per call site
	assign new_frame = '{ret_pc: instr_pc + 16'h0001, num: instr.num, param: is_pcall, dst: instr.dst};
	// R7 push on valid call
	assign push = take & any_call & call_ok & is_call | (state == SCS_COPY_IN) & (cnt == 2'h3);
	// R20 pop after outputs copied
	assign pop  = ret_take & ~top.param | out_last;

	// the taken instruction may change during the input copy, so a parameter
	// call pushes the frame captured at its take
	assign stack_frame = (state == SCS_COPY_IN) ? pend_frame : new_frame;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_frame <= '0;
		end else if (take & any_call) begin
			pend_frame <= new_frame;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			SCS_IDLE: begin
				// R14 enter input copy
				if (take & any_call & call_ok & is_pcall) begin
					next_state = SCS_COPY_IN;
				end else if (ret_take & top.param) begin
					next_state = SCS_COPY_OUT;
				end
			end
			SCS_COPY_IN: begin
				if (cnt == 2'h3) begin
					next_state = SCS_IDLE;
				end
			end
			SCS_COPY_OUT: begin
				if (cnt == 2'h3) begin
					next_state = SCS_IDLE;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// parameter word moves
	// ------------------------------------------------------------
	logic copy_in;
	logic copy_out;
	assign copy_in  = state == SCS_COPY_IN;
	assign copy_out = state == SCS_COPY_OUT;

	// R16 four words each way
	assign mem_rd      = copy_in;
	assign mem_wr      = copy_out;
	assign mem_addr    = base + {14'h0000, cnt};
	assign mem_wdata   = macro_rdata;
	// R14 macro inputs filled
	assign macro_wr    = copy_in;
	assign macro_wdata = mem_rdata;
	// R15 macro outputs read
	assign macro_idx   = (copy_in ? scs_pkg::MACRO_IN0 : scs_pkg::MACRO_OUT0) + {1'b0, cnt};

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic                     jump_now;
	logic [scs_pkg::PC_W-1:0] jump_tgt;

	// R7 jump at once on plain call or return, else after the last copied word
	assign jump_now = take & any_call & call_ok & is_call | ret_take & ~top.param | cnt_last & ~idle;
	assign jump_tgt = idle ? (is_ret ? top.ret_pc : entry.pc) : pend_pc;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= SCS_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= idle ? 2'h0 : cnt + 2'h1;
		end
	end

	// R6 flag tracks last call
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			error_flag <= 1'b0;
			err_cause  <= scs_pkg::SCS_ERR_NONE;
		end else if (take & any_call) begin
			error_flag <= ~call_ok;
			err_cause  <= cause;
		end
	end

	// copy base and resume address
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			base    <= '0;
			pend_pc <= scs_pkg::PC_RESET;
		end else if (take & any_call) begin
			base    <= instr.src;
			pend_pc <= entry.pc;
		end else if (ret_take) begin
			base    <= top.dst;
			pend_pc <= top.ret_pc;
		end
	end

	// R15 resume after copy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jump    <= 1'b0;
			jump_pc <= scs_pkg::PC_RESET;
		end else begin
			jump <= jump_now;
			if (jump_now) begin
				jump_pc <= jump_tgt;
			end
		end
	end

	logic unused_ok;
	assign unused_ok = nop_call | is_entry;
endmodule : scs_sequencer
`default_nettype wire

// [design/scs_stack.sv]
// scs_stack: 16-deep last-in first-out store of return frames.
// assumes the caller never pushes when full nor pops when empty.
`default_nettype none
module scs_stack (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         push,
	input  wire logic                         pop,
	input  wire scs_pkg::scs_frame_t          push_frame,
	output scs_pkg::scs_frame_t               top_frame,
	output logic [scs_pkg::SP_W-1:0]          depth,
	output logic [scs_pkg::NUM_SUBS-1:0]      active
);
	scs_pkg::scs_frame_t mem [scs_pkg::STACK_DEPTH];
	logic [scs_pkg::SP_W-1:0] next_depth;
	logic [scs_pkg::SP_W-1:0] top_idx;

	assign next_depth = push ? depth + 5'h01 : (pop ? depth - 5'h01 : depth);
	assign top_idx    = depth - 5'h01;
	assign top_frame  = mem[top_idx[3:0]];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			depth  <= '0;
			active <= '0;
		end else begin
			depth <= next_depth;
			if (push) begin
				mem[depth[3:0]]          <= push_frame;
				active[push_frame.num]   <= 1'b1;
			end else if (pop) begin
				active[top_frame.num]    <= 1'b0;
			end
		end
	end
endmodule : scs_stack
`default_nettype wire

// [tb/scs_prog_model.sv]
// scs_prog_model: data memory and shared macro area beside the sequencer.
// assumes same-cycle reads; writes land on the rising edge.
`default_nettype none
module scs_prog_model (
	input  wire logic        clk,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	input  wire logic [2:0]  macro_idx,
	input  wire logic        macro_wr,
	input  wire logic [15:0] macro_wdata,
	output logic      [15:0] macro_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] dmem [0:255];
	logic [15:0] macro [0:7];
	// idle read port shows the inverse, never a held word
	assign mem_rdata = mem_rd ? dmem[mem_addr[7:0]] : ~dmem[mem_addr[7:0]];
	assign macro_rdata = macro[macro_idx];
	always @(posedge clk) begin
		if (mem_wr) dmem[mem_addr[7:0]] <= mem_wdata;
		if (macro_wr) macro[macro_idx] <= macro_wdata;
	end
endmodule : scs_prog_model
`default_nettype wire

// [tb/scs_sequencer_assertions.sv]
// scs_sequencer_assertions: port timing checks of the call sequencer.
// assumes it is bound to scs_sequencer; one clock, sync reset.
`default_nettype none
module scs_sequencer_assertions (
	input wire logic                     clk,
	input wire logic                     sys_rst,
	input wire logic                     instr_valid,
	input wire scs_pkg::scs_instr_t      instr,
	input wire logic                     instr_ready,
	input wire logic                     jump,
	input wire logic                     error_flag,
	input wire logic [scs_pkg::SP_W-1:0] nest_depth,
	input wire logic                     mem_rd,
	input wire logic                     mem_wr,
	input wire logic [scs_pkg::PC_W-1:0] mem_addr,
	input wire logic [2:0]               macro_idx,
	input wire logic                     macro_wr
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire logic tk = instr_valid && instr_ready && instr.opcode == scs_pkg::OPC_CALL;
	wire logic tk_call = tk && !instr.interlocked;
	wire logic tk_il = tk && instr.interlocked;
	wire logic tk_ret = instr_valid && instr_ready && instr.opcode == scs_pkg::OPC_RETURN && nest_depth != 5'h00;
	sequence s_copy_in;
		mem_rd && macro_wr && macro_idx == 3'h0 ##1 macro_wr && macro_idx == 3'h1
			##1 macro_wr && macro_idx == 3'h2 ##1 macro_wr && macro_idx == 3'h3 ##1 jump;
	endsequence
	sequence s_copy_out;
		mem_wr && macro_idx == 3'h4 ##1 mem_wr && macro_idx == 3'h5
			##1 mem_wr && macro_idx == 3'h6 ##1 mem_wr && macro_idx == 3'h7 ##1 jump;
	endsequence
	a_call_answers: assert property (tk_call |=> jump != error_flag)
		else $error("call gave no single answer");
	a_call_pushes: assert property (tk_call ##1 jump |-> nest_depth == $past(nest_depth) + 5'h01)
		else $error("call did not deepen by one");
	a_depth_limit: assert property (tk_call && nest_depth == 5'h10 |=> !jump && error_flag)
		else $error("call past full stack accepted");
	a_interlock_noop: assert property (tk_il |=> !jump && $stable(error_flag) && $stable(nest_depth))
		else $error("interlocked call acted");
	a_ret_jumps: assert property (tk_ret |-> ##[1:5] jump)
		else $error("return gave no jump");
	a_copy_in: assert property ($rose(macro_wr) |-> s_copy_in)
		else $error("bad input copy");
	a_copy_out: assert property ($rose(mem_wr) |-> s_copy_out)
		else $error("bad output copy");
	a_addr_steps: assert property ((macro_wr && macro_idx != 3'h0) || (mem_wr && macro_idx != 3'h4)
		|-> mem_addr == $past(mem_addr) + 16'h0001)
		else $error("copy address not stepping");
	a_busy_refuses: assert property ((mem_rd || mem_wr) |-> !instr_ready)
		else $error("instruction offered as taken during a word copy");
endmodule : scs_sequencer_assertions
bind scs_sequencer scs_sequencer_assertions u_chk (.*);
`default_nettype wire

// [tb/subroutine_call_sequencer_tb.sv]
// subroutine_call_sequencer_tb: directed call, return and parameter tests.
// assumes scs_prog_model stands for data memory and the macro area.
`default_nettype none
module subroutine_call_sequencer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, load_en = 1'b0;
	logic                instr_ready, jump, error_flag, mem_rd, mem_wr, macro_wr;
	logic [15:0]         instr_pc = 16'h0000, jump_pc, mem_addr, mem_wdata, mem_rdata, macro_wdata, macro_rdata;
	logic [9:0]          load_num = 10'h000;
	logic [4:0]          nest_depth;
	logic [2:0]          macro_idx;
	scs_pkg::scs_instr_t instr = '0;
	scs_pkg::scs_entry_t load_entry = '0;
	scs_pkg::scs_err_t   err_cause;
	scs_pkg::scs_err_t   err_cause_red;
	logic                error_flag_red;
	int                  mismatches = 0;
	int                  checks = 0;
	scs_sequencer dut (.*);
	scs_prog_model u_prog (.*);
	// same stream into a reduced-range copy
	scs_sequencer #(
		.REDUCED (1'b1)
	) dut_red (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.instr_valid (instr_valid),
		.instr       (instr),
		.instr_pc    (instr_pc),
		.instr_ready (),
		.jump        (),
		.jump_pc     (),
		.error_flag  (error_flag_red),
		.err_cause   (err_cause_red),
		.nest_depth  (),
		.load_en     (load_en),
		.load_num    (load_num),
		.load_entry  (load_entry),
		.mem_rd      (),
		.mem_wr      (),
		.mem_addr    (),
		.mem_wdata   (),
		.mem_rdata   (mem_rdata),
		.macro_idx   (),
		.macro_wr    (),
		.macro_wdata (),
		.macro_rdata (macro_rdata)
	);
	always #2 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic load(input logic [9:0] n, input logic [7:0] t);
		@(posedge clk) #1;
		load_en = 1'b1;
		load_num = n;
		load_entry = '{1'b1, {6'h20, n}, t};
		@(posedge clk) #1;
		load_en = 1'b0;
	endtask : load
	task automatic step(input logic [9:0] op, n, input logic [15:0] pc, epc, input logic il,
		input scs_pkg::scs_err_t ec, input logic [4:0] ed);
		logic ok;
		ok = !il && ec == scs_pkg::SCS_ERR_NONE;
		@(posedge clk) #1;
		instr_valid = 1'b1;
		instr = '{op, n, 16'h0010, 16'h0040, il, 8'h01};
		instr_pc = pc;
		@(posedge clk) #1;
		instr_valid = 1'b0;
		for (int k = 0; k < 6 && ok && jump !== 1'b1; k++) @(posedge clk) #1;
		chk(jump, ok);
		if (ok) chk(jump_pc, epc);
		if (op != scs_pkg::OPC_RETURN) chk({error_flag, err_cause}, {ec != scs_pkg::SCS_ERR_NONE, ec});
		chk(nest_depth, ed);
	endtask : step
	task automatic call(input logic [9:0] n, input logic [15:0] pc, input scs_pkg::scs_err_t ec, input logic [4:0] ed);
		step(scs_pkg::OPC_CALL, n, pc, {6'h20, n}, 1'b0, ec, ed);
	endtask : call
	task automatic ret(input logic [15:0] epc, input logic [4:0] ed);
		step(scs_pkg::OPC_RETURN, 10'h000, 16'h0000, epc, 1'b0, scs_pkg::SCS_ERR_NONE, ed);
	endtask : ret
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// ----------------
	// scenarios
	// ----------------
	task automatic t_calls;
		call(10'h007, 16'h0010, scs_pkg::SCS_ERR_MISSING, 5'h00);
		step(scs_pkg::OPC_CALL, 10'h005, 16'h0010, 16'h8005, 1'b1, scs_pkg::SCS_ERR_MISSING, 5'h00);
		call(10'h005, 16'h0010, scs_pkg::SCS_ERR_NONE, 5'h01);
		call(10'h005, 16'h8006, scs_pkg::SCS_ERR_SELF, 5'h01);
		call(10'h006, 16'h8007, scs_pkg::SCS_ERR_NONE, 5'h02);
		call(10'h005, 16'h8008, scs_pkg::SCS_ERR_ACTIVE, 5'h02);
		ret(16'h8008, 5'h01);
		ret(16'h0011, 5'h00);
		call(10'h005, 16'h0040, scs_pkg::SCS_ERR_NONE, 5'h01);
		ret(16'h0041, 5'h00);
		call(10'h008, 16'h0010, scs_pkg::SCS_ERR_TASK, 5'h00);
		$display("t_calls done");
	endtask : t_calls
	task automatic t_depth;
		for (int i = 0; i < 16; i++) call((i == 15) ? 10'h3ff : 10'(16 + i), 16'h0100 + 16'(i),
			scs_pkg::SCS_ERR_NONE, 5'(i + 1));
		chk({error_flag_red, err_cause_red}, {1'b1, scs_pkg::SCS_ERR_MISSING});
		call(10'h01f, 16'h0110, scs_pkg::SCS_ERR_DEPTH, 5'h10);
		for (int i = 15; i >= 0; i--) ret(16'h0101 + 16'(i), 5'(i));
		$display("t_depth done");
	endtask : t_depth
	task automatic t_param;
		step(scs_pkg::OPC_PCALL, 10'h009, 16'h0030, 16'h8009, 1'b0, scs_pkg::SCS_ERR_NONE, 5'h01);
		for (int k = 0; k < 4; k++) chk(u_prog.macro[k], 16'ha010 + 16'(k));
		chk(u_prog.macro[4], 16'h0000);
		for (int k = 4; k < 8; k++) u_prog.macro[k] = 16'hb000 + 16'(k);
		ret(16'h0031, 5'h00);
		for (int k = 0; k < 4; k++) chk(u_prog.dmem[64 + k], 16'hb004 + 16'(k));
		chk(u_prog.dmem[68], 16'ha044);
		$display("t_param done");
	endtask : t_param
	initial begin
		for (int k = 0; k < 256; k++) u_prog.dmem[k] = 16'ha000 + 16'(k);
		for (int k = 0; k < 8; k++) u_prog.macro[k] = 16'h0000;
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int k = 5; k < 32; k++) if (k != 7) load(10'(k), (k == 8) ? 8'h02 : 8'h01);
		load(10'h3ff, 8'h01);
		t_calls();
		t_depth();
		t_param();
		final_report();
	end
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
endmodule : subroutine_call_sequencer_tb
`default_nettype wire
